// file: cbm_pkg.sv
package cbm_pkg;

	// ----------------------------------------
	// Opcodes and exit offsets
	// ----------------------------------------
	localparam logic [15:0] OP_MOVE = 16'h5000;
	localparam logic [15:0] OP_UNPK = 16'h5200;
	localparam logic [15:0] OP_PACK = 16'h5400;
	localparam logic [7:0] OP_RDCHK = 8'h56;
	localparam logic [7:0] OP_LDCHK = 8'h57;
	localparam logic [15:0] OFS_NEXT = 16'h0001;
	localparam logic [15:0] OFS_PAR = 16'h0009;
	localparam logic [15:0] OFS_LIM = 16'h000a;

	// ----------------------------------------
	// Macro control word fields
	// ----------------------------------------
	localparam int CB_PAR_EN = 0;
	localparam int CB_PAR_ODD = 1;
	localparam int CB_DISC_EN = 2;
	localparam int CB_CMP_EN = 3;
	localparam int CB_NMASK_LO = 4;
	localparam int CB_NMASK_HI = 6;
	localparam int CB_CHK_EN = 7;
	localparam int CB_CRC_SEL = 8;
	localparam int CB_LIM_EN = 9;
	localparam int CB_DST_INC = 10;

	// ----------------------------------------
	// Array, accumulator and timing constants
	// ----------------------------------------
	localparam int MASK_DEPTH = 16;
	localparam logic [3:0] DISC_IDX = 4'h8;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [15:0] ACC_RST = 16'h0000;
	localparam int CLK_NS = 20;
	localparam int CHAR_NS = 5000;
	localparam int CHAR_CYC = CHAR_NS / CLK_NS;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {OPK_NONE, OPK_MOVE, OPK_UNPK, OPK_PACK, OPK_RDCHK, OPK_LDCHK} cbm_op_e;
	typedef enum logic [2:0] {EX_NONE, EX_NEXT, EX_MASK, EX_PAR, EX_LIM, EX_IRQ} cbm_exit_e;

	typedef struct packed {
		logic [15:0] src;
		logic [15:0] dst;
		logic [15:0] limit;
		logic [15:0] ctrl;
	} cbm_ctx_s;

	typedef struct packed {
		logic [15:0] opcode;
		logic [15:0] pc;
		logic [15:0] gr_val;
	} cbm_cmd_s;

	typedef struct packed {
		logic req;
		logic we;
		logic [14:0] addr;
		logic [1:0] be;
		logic [15:0] wdata;
	} cbm_mem_s;

	typedef struct packed {
		cbm_exit_e kind;
		logic [15:0] npc;
	} cbm_res_s;

	// Opcode decode, shared by control and checks
	function automatic cbm_op_e cbm_decode(input logic [15:0] op);
		cbm_op_e k;
		k = OPK_NONE;
		if (op == OP_MOVE)
			k = OPK_MOVE;
		else if (op == OP_UNPK)
			k = OPK_UNPK;
		else if (op == OP_PACK)
			k = OPK_PACK;
		else if (op[15:8] == OP_RDCHK && op[3:0] == 4'h0)
			k = OPK_RDCHK;
		else if (op[15:8] == OP_LDCHK && op[3:0] == 4'h0)
			k = OPK_LDCHK;
		return k;
	endfunction

endpackage

// file: cbm_buf.sv
module cbm_buf import cbm_pkg::*; #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] d0_r, d0_nxt, d1_r, d1_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic push, pop;

	// Handshakes
	assign in_ready = cnt_r != 2'h2;
	assign out_valid = cnt_r != 2'h0;
	assign out_data = d0_r;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Two-entry queue, head in d0
	always_comb begin
		d0_nxt = d0_r;
		d1_nxt = d1_r;
		cnt_nxt = cnt_r;
		unique case ({push, pop})
			2'b10: begin
				if (cnt_r == 2'h0)
					d0_nxt = in_data;
				else
					d1_nxt = in_data;
				cnt_nxt = cnt_r + 2'h1;
			end
			2'b01: begin
				d0_nxt = d1_r;
				cnt_nxt = cnt_r - 2'h1;
			end
			2'b11: begin
				if (cnt_r == 2'h1) begin
					d0_nxt = in_data;
				end else begin
					d0_nxt = d1_r;
					d1_nxt = in_data;
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			d0_r <= '0;
			d1_r <= '0;
			cnt_r <= 2'h0;
		end else if (ce) begin
			d0_r <= d0_nxt;
			d1_r <= d1_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule

// file: cbm_mem.sv
module cbm_mem import cbm_pkg::*; #(
	parameter int W = 8,
	parameter int DEPTH = MASK_DEPTH,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [DEPTH];

	// Mask array, registered read
	always_ff @(posedge clk) begin
		if (ce) begin
			if (we)
				mem[waddr] <= wdata;
			rdata <= mem[raddr];
		end
	end
endmodule

// file: cbm_core.sv
// Behaviour
// - Parity error on the moved byte exits to P+9.
// - Block limit reaching zero after a byte exits to P+10.
// - Byte equal to mask N (1..8) exits to P+N.
// - With no exit condition the move repeats on the next byte.
// - A pending interrupt is taken after each single byte.
// - Move context lives in upper registers; general registers 1-7 untouched.
// - Opcode 5400 packs, 5200 unpacks, both with all move functions.
// - Read/load check are short format; any general register selectable.
// - Read check copies accumulator out; load check writes it in.
// - Fetch at source, store at destination, bump pointers, count limit.
// - Control word selects compares, discards and CRC16 or LRC.
// - Each character is processed within 5 us of own time.
module cbm_core import cbm_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire cbm_cmd_s cmd,
	input wire cbm_ctx_s ctx_i,
	output cbm_ctx_s ctx_o,
	input wire logic irq_pending,
	input wire logic mask_we,
	input wire logic [3:0] mask_idx,
	input wire logic [7:0] mask_wdata,
	output cbm_mem_s mem_o,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	output logic done,
	output cbm_res_s result,
	output logic gr_we,
	output logic [3:0] gr_sel,
	output logic [15:0] gr_wdata,
	output logic [15:0] accum
);
	typedef enum logic [2:0] {S_IDLE, S_FETCH, S_CHECK, S_STORE, S_CMPA, S_CMPB, S_UPD} cbm_st_e;

	cbm_st_e st_r, st_nxt;
	cbm_ctx_s ctx_r, ctx_nxt;
	cbm_mem_s mem_r, mem_nxt;
	cbm_res_s res_r, res_nxt;
	cbm_op_e mode_r, mode_nxt;
	logic [15:0] acc_r, acc_nxt, pc_r, pc_nxt, gr_wdata_r, gr_wdata_nxt;
	logic [7:0] byte_r, byte_nxt, mask_rd, fetch_byte, head;
	logic [3:0] gr_sel_r, gr_sel_nxt, mask_raddr;
	logic [2:0] idx_r, idx_nxt;
	logic [8:0] cyc_r, cyc_nxt;
	logic perr_r, perr_nxt, disc_r, disc_nxt, hit_r, hit_nxt;
	logic done_r, done_nxt, gr_we_r, gr_we_nxt;
	logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;

	// CRC16 over one byte, reflected form
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		return r;
	endfunction

	// ----------------------------------------
	// Byte path and mask array
	// ----------------------------------------
	// Pack source holds one byte per word in the low half
	assign fetch_byte = (mode_r == OPK_PACK) ? mem_rdata[7:0] :
		(ctx_r.src[0] ? mem_rdata[7:0] : mem_rdata[15:8]);
	assign buf_in_valid = (st_r == S_FETCH) && mem_r.req && mem_ack;
	assign buf_out_ready = (st_r == S_STORE) && (disc_r || (mem_r.req && mem_ack));
	// Discard character sits at index 8 of the array, after the eight masks
	assign mask_raddr = (st_r == S_CMPA) ? {1'b0, idx_r} : DISC_IDX;

	cbm_buf #(.W(8)) u_buf (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(fetch_byte),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(head)
	);

	cbm_mem #(.W(8), .DEPTH(MASK_DEPTH), .AW(4)) u_mask (
		.clk(clk),
		.ce(ce),
		.we(mask_we),
		.waddr(mask_idx),
		.wdata(mask_wdata),
		.raddr(mask_raddr),
		.rdata(mask_rd)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	assign cmd_ready = st_r == S_IDLE;

	// Next-state and datapath updates
	always_comb begin
		logic [15:0] lim_new;
		lim_new = ctx_r.limit - 16'h0001;
		st_nxt = st_r;
		ctx_nxt = ctx_r;
		mem_nxt = mem_r;
		res_nxt = res_r;
		mode_nxt = mode_r;
		acc_nxt = acc_r;
		pc_nxt = pc_r;
		byte_nxt = byte_r;
		idx_nxt = idx_r;
		perr_nxt = perr_r;
		disc_nxt = disc_r;
		hit_nxt = hit_r;
		done_nxt = 1'b0;
		gr_we_nxt = 1'b0;
		gr_sel_nxt = gr_sel_r;
		gr_wdata_nxt = gr_wdata_r;
		// Own cycles per character, waits on memory excluded
		cyc_nxt = (st_r == S_IDLE || st_r == S_UPD) ? 9'h000 :
			((mem_r.req || cyc_r == 9'h1ff) ? cyc_r : cyc_r + 9'h001);
		unique case (st_r)
			S_IDLE: begin
				if (cmd_valid) begin
					pc_nxt = cmd.pc;
					unique case (cbm_decode(cmd.opcode))
						OPK_MOVE, OPK_UNPK, OPK_PACK: begin
							mode_nxt = cbm_decode(cmd.opcode);
							ctx_nxt = ctx_i;
							st_nxt = S_FETCH;
						end
						OPK_RDCHK: begin
							gr_we_nxt = 1'b1;
							gr_sel_nxt = cmd.opcode[7:4];
							gr_wdata_nxt = acc_r;
							done_nxt = 1'b1;
							res_nxt = '{kind: EX_NEXT, npc: cmd.pc + OFS_NEXT};
						end
						OPK_LDCHK: begin
							acc_nxt = cmd.gr_val;
							done_nxt = 1'b1;
							res_nxt = '{kind: EX_NEXT, npc: cmd.pc + OFS_NEXT};
						end
						OPK_NONE: ;
					endcase
				end
			end
			S_FETCH: begin
				// Back-pressure: no read while the buffer is full
				if (!mem_r.req && buf_in_ready) begin
					mem_nxt = '{req: 1'b1, we: 1'b0, addr: ctx_r.src[15:1], be: 2'b11, wdata: 16'h0000};
				end else if (mem_r.req && mem_ack) begin
					mem_nxt.req = 1'b0;
					st_nxt = S_CHECK;
				end
			end
			S_CHECK: begin
				byte_nxt = head;
				perr_nxt = ctx_r.ctrl[CB_PAR_EN] && ((^head) != ctx_r.ctrl[CB_PAR_ODD]);
				disc_nxt = ctx_r.ctrl[CB_DISC_EN] && (head == mask_rd);
				if (!disc_nxt && ctx_r.ctrl[CB_CHK_EN])
					acc_nxt = ctx_r.ctrl[CB_CRC_SEL] ? crc_step(acc_r, head) : {acc_r[15:8], acc_r[7:0] ^ head};
				if (!disc_nxt) begin
					if (mode_r == OPK_UNPK)
						mem_nxt = '{req: 1'b1, we: 1'b1, addr: ctx_r.dst[15:1], be: 2'b11, wdata: {8'h00, head}};
					else
						mem_nxt = '{req: 1'b1, we: 1'b1, addr: ctx_r.dst[15:1],
							be: ctx_r.dst[0] ? 2'b01 : 2'b10, wdata: {head, head}};
				end
				st_nxt = S_STORE;
			end
			S_STORE: begin
				if (disc_r || (mem_r.req && mem_ack)) begin
					mem_nxt.req = 1'b0;
					idx_nxt = 3'h0;
					hit_nxt = 1'b0;
					st_nxt = (ctx_r.ctrl[CB_CMP_EN] && !disc_r) ? S_CMPA : S_UPD;
				end
			end
			S_CMPA: st_nxt = S_CMPB;
			S_CMPB: begin
				// Lowest mask number is tried first
				if (mask_rd == byte_r) begin
					hit_nxt = 1'b1;
					st_nxt = S_UPD;
				end else if (idx_r == ctx_r.ctrl[CB_NMASK_HI:CB_NMASK_LO]) begin
					st_nxt = S_UPD;
				end else begin
					idx_nxt = idx_r + 3'h1;
					st_nxt = S_CMPA;
				end
			end
			S_UPD: begin
				ctx_nxt.src = ctx_r.src + ((mode_r == OPK_PACK) ? 16'h0002 : 16'h0001);
				if (!disc_r && ctx_r.ctrl[CB_DST_INC])
					ctx_nxt.dst = ctx_r.dst + ((mode_r == OPK_UNPK) ? 16'h0002 : 16'h0001);
				if (!disc_r && ctx_r.ctrl[CB_LIM_EN])
					ctx_nxt.limit = lim_new;
				st_nxt = S_IDLE;
				done_nxt = 1'b1;
				if (perr_r)
					res_nxt = '{kind: EX_PAR, npc: pc_r + OFS_PAR};
				else if (!disc_r && ctx_r.ctrl[CB_LIM_EN] && lim_new == 16'h0000)
					res_nxt = '{kind: EX_LIM, npc: pc_r + OFS_LIM};
				else if (hit_r)
					res_nxt = '{kind: EX_MASK, npc: pc_r + {13'h0000, idx_r} + OFS_NEXT};
				else if (irq_pending)
					res_nxt = '{kind: EX_IRQ, npc: pc_r};
				else begin
					done_nxt = 1'b0;
					st_nxt = S_FETCH;
				end
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= S_IDLE;
			ctx_r <= '0;
			mem_r <= '0;
			res_r <= '{kind: EX_NONE, npc: 16'h0000};
			mode_r <= OPK_NONE;
			acc_r <= ACC_RST;
			pc_r <= 16'h0000;
			byte_r <= 8'h00;
			idx_r <= 3'h0;
			perr_r <= 1'b0;
			disc_r <= 1'b0;
			hit_r <= 1'b0;
			done_r <= 1'b0;
			gr_we_r <= 1'b0;
			gr_sel_r <= 4'h0;
			gr_wdata_r <= 16'h0000;
			cyc_r <= 9'h000;
		end else if (ce) begin
			st_r <= st_nxt;
			ctx_r <= ctx_nxt;
			mem_r <= mem_nxt;
			res_r <= res_nxt;
			mode_r <= mode_nxt;
			acc_r <= acc_nxt;
			pc_r <= pc_nxt;
			byte_r <= byte_nxt;
			idx_r <= idx_nxt;
			perr_r <= perr_nxt;
			disc_r <= disc_nxt;
			hit_r <= hit_nxt;
			done_r <= done_nxt;
			gr_we_r <= gr_we_nxt;
			gr_sel_r <= gr_sel_nxt;
			gr_wdata_r <= gr_wdata_nxt;
			cyc_r <= cyc_nxt;
		end
	end

	// Outputs from registers
	assign ctx_o = ctx_r;
	assign mem_o = mem_r;
	assign done = done_r;
	assign result = res_r;
	assign gr_we = gr_we_r;
	assign gr_sel = gr_sel_r;
	assign gr_wdata = gr_wdata_r;
	assign accum = acc_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	par_exit_a: assert property (@(posedge clk) disable iff (rst || !ce)
		st_r == S_UPD && perr_r |=> done && result.kind == EX_PAR && result.npc == $past(pc_r) + 16'h0009)
		else $error("parity exit not at P+9");
	lim_exit_a: assert property (@(posedge clk) disable iff (rst || !ce)
		done && result.kind == EX_LIM |-> result.npc == pc_r + 16'h000a && ctx_r.limit == 16'h0000)
		else $error("limit exit wrong");
	mask_exit_a: assert property (@(posedge clk) disable iff (rst || !ce)
		done && result.kind == EX_MASK |-> result.npc - pc_r >= 16'h0001 && result.npc - pc_r <= 16'h0008
		&& result.npc - pc_r == {13'h0000, idx_r} + 16'h0001)
		else $error("mask exit offset wrong");
	loop_on_a: assert property (@(posedge clk) disable iff (rst || !ce)
		st_r == S_UPD && !perr_r && !hit_r && !irq_pending && !(ctx_r.ctrl[CB_LIM_EN] && !disc_r
		&& ctx_r.limit == 16'h0001) |=> st_r == S_FETCH && !done)
		else $error("move did not loop");
	irq_window_a: assert property (@(posedge clk) disable iff (rst || !ce)
		st_r == S_UPD && irq_pending && !perr_r && !hit_r |=> done && ((result.kind == EX_IRQ
		&& result.npc == $past(pc_r)) || result.kind == EX_LIM))
		else $error("interrupt window missed");
	gr_quiet_a: assert property (@(posedge clk) disable iff (rst || !ce)
		gr_we |-> $past(st_r) == S_IDLE && $past(cbm_decode(cmd.opcode)) == OPK_RDCHK)
		else $error("general register written by move");
	mode_dec_a: assert property (@(posedge clk) disable iff (rst || !ce)
		cmd_valid && cmd_ready && cmd.opcode == 16'h5400 |=> mode_r == OPK_PACK && st_r == S_FETCH)
		else $error("pack opcode not decoded");
	rd_check_a: assert property (@(posedge clk) disable iff (rst || !ce)
		cmd_valid && cmd_ready && cbm_decode(cmd.opcode) == OPK_RDCHK |=> gr_we && gr_sel == $past(cmd.opcode[7:4])
		&& gr_wdata == $past(acc_r))
		else $error("read check wrong");
	ld_check_a: assert property (@(posedge clk) disable iff (rst || !ce)
		cmd_valid && cmd_ready && cbm_decode(cmd.opcode) == OPK_LDCHK |=> accum == $past(cmd.gr_val) && done)
		else $error("load check wrong");
	src_step_a: assert property (@(posedge clk) disable iff (rst || !ce)
		st_r == S_UPD |=> ctx_r.src == $past(ctx_r.src) + (($past(mode_r) == OPK_PACK) ? 16'h0002 : 16'h0001))
		else $error("source pointer step wrong");
	discard_a: assert property (@(posedge clk) disable iff (rst || !ce)
		st_r == S_STORE && disc_r |-> !(mem_r.req && mem_r.we) ##1 st_r == S_UPD)
		else $error("discarded byte stored");
	char_time_a: assert property (@(posedge clk) disable iff (rst || !ce)
		cyc_r <= 9'(CHAR_CYC))
		else $error("character time exceeded");
	prio_a: assert property (@(posedge clk) disable iff (rst || !ce)
		st_r == S_UPD && perr_r && hit_r |=> result.kind == EX_PAR)
		else $error("exit priority wrong");
endmodule

// file: cbm_tb.sv
module tb import cbm_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic ce = 1'h1;
	logic cmd_valid = 1'h0;
	logic irq_pending = 1'h0;
	logic mask_we = 1'h0;
	logic mem_ack = 1'h0;
	logic [3:0] mask_idx = 4'h0;
	logic [7:0] mask_wdata = 8'h00;
	logic [15:0] mem_rdata = 16'h0000;
	cbm_cmd_s cmd = '0;
	cbm_ctx_s ctx_i = '0;
	cbm_ctx_s ctx_o;
	cbm_mem_s mem_o;
	cbm_res_s result;
	logic cmd_ready;
	logic done;
	logic gr_we;
	logic [3:0] gr_sel;
	logic [15:0] gr_wdata;
	logic [15:0] accum;
	logic [15:0] mem [0:255];
	int fails = 0;
	int comparisons = 0;
	int ack_dly = 0;
	int wait_n = 0;
	int gr_cnt = 0;
	int cyc = 0;

	cbm_core uut (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready),
		.cmd(cmd),
		.ctx_i(ctx_i),
		.ctx_o(ctx_o),
		.irq_pending(irq_pending),
		.mask_we(mask_we),
		.mask_idx(mask_idx),
		.mask_wdata(mask_wdata),
		.mem_o(mem_o),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata),
		.done(done),
		.result(result),
		.gr_we(gr_we),
		.gr_sel(gr_sel),
		.gr_wdata(gr_wdata),
		.accum(accum)
	);

	// 50 MHz clock
	always #10 clk = ~clk;

	// ----------------------------------------
	// Memory model, ack after ack_dly waits
	// ----------------------------------------
	always @(posedge clk) begin
		if (mem_ack) begin
			mem_ack <= 1'h0;
			mem_rdata <= ~mem_rdata; // Stale data must not look valid
		end else if (mem_o.req && wait_n >= ack_dly) begin
			mem_ack <= 1'h1;
			wait_n <= 0;
			if (!mem_o.we)
				mem_rdata <= mem[mem_o.addr[7:0]];
			if (mem_o.we && mem_o.be[1])
				mem[mem_o.addr[7:0]][15:8] <= mem_o.wdata[15:8];
			if (mem_o.we && mem_o.be[0])
				mem[mem_o.addr[7:0]][7:0] <= mem_o.wdata[7:0];
		end else if (mem_o.req) begin
			wait_n <= wait_n + 1;
		end else begin
			mem_rdata <= ~mem_rdata;
		end
	end

	// Count register writes, none expected during moves
	always @(posedge clk) begin
		if (gr_we === 1'h1)
			gr_cnt <= gr_cnt + 1;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Reflected CRC16 step over one byte
	function automatic logic [15:0] crc_step(input logic [15:0] a, input logic [7:0] b);
		logic [15:0] c;
		c = a ^ {8'h00, b};
		for (int k = 0; k < 8; k++)
			c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		return c;
	endfunction

	task automatic set_mask(input logic [3:0] i, input logic [7:0] v);
		@(posedge clk);
		mask_we <= 1'h1;
		mask_idx <= i;
		mask_wdata <= v;
		@(posedge clk);
		mask_we <= 1'h0;
	endtask

	// Issue one instruction at P=0100 and wait for done
	task automatic run(input logic [15:0] op, input logic [15:0] gv, input cbm_ctx_s cx);
		@(posedge clk);
		cmd_valid <= 1'h1;
		cmd <= '{op, 16'h0100, gv};
		ctx_i <= cx;
		@(posedge clk);
		cmd_valid <= 1'h0;
		cyc = 0;
		// Done of a check stands only in the cycle after the taking edge
		#1;
		while (done !== 1'h1 && cyc < 2000) begin
			@(posedge clk);
			#1;
			cyc++;
		end
		chk("done", 32'h1, {31'h0, done});
	endtask

	task automatic res(input cbm_exit_e k, input logic [15:0] o);
		chk("exit kind", {29'h0, k}, {29'h0, result.kind});
		chk("exit npc", {16'h0, 16'h0100 + o}, {16'h0, result.npc});
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_check();
		// Load offered with clock enable low must not be taken
		@(posedge clk);
		ce <= 1'h0;
		cmd_valid <= 1'h1;
		cmd <= '{16'h57a0, 16'h0100, 16'hbeef};
		repeat (3) @(posedge clk);
		#1;
		chk("frozen accum", {16'h0, ACC_RST}, {16'h0, accum});
		chk("frozen done", 32'h0, {31'h0, done});
		chk("cmd_ready", 32'h1, {31'h0, cmd_ready});
		@(posedge clk);
		cmd_valid <= 1'h0;
		ce <= 1'h1;
		run(16'h5750, 16'h1234, '0);
		chk("accum", 32'h1234, {16'h0, accum});
		run(16'h56f0, 16'h0000, '0);
		chk("gr_we", 32'h1, {31'h0, gr_we});
		chk("gr_sel", 32'hf, {28'h0, gr_sel});
		chk("gr_wdata", 32'h1234, {16'h0, gr_wdata});
		res(EX_NEXT, 16'h0001);
	endtask

	task automatic t_limit();
		run(16'h5700, 16'h0000, '0);
		mem[8'h10] = 16'h1234;
		mem[8'h20] = 16'h0000;
		run(OP_MOVE, 16'h0000, '{16'h0020, 16'h0040, 16'h0002, 16'h0680});
		res(EX_LIM, 16'h000a);
		chk("src", 32'h22, {16'h0, ctx_o.src});
		chk("dst", 32'h42, {16'h0, ctx_o.dst});
		chk("limit", 32'h0, {16'h0, ctx_o.limit});
		chk("stored", 32'h1234, {16'h0, mem[8'h20]});
		chk("lrc", 32'h0026, {16'h0, accum});
	endtask

	task automatic t_disc();
		set_mask(4'h8, 8'h12);
		run(16'h5700, 16'h0000, '0);
		mem[8'h70] = 16'h0000;
		run(OP_MOVE, 16'h0000, '{16'h0020, 16'h00e0, 16'h0001, 16'h0784});
		res(EX_LIM, 16'h000a);
		chk("disc store", 32'h3400, {16'h0, mem[8'h70]});
		chk("disc dst", 32'he1, {16'h0, ctx_o.dst});
		chk("crc", {16'h0, crc_step(16'h0000, 8'h34)}, {16'h0, accum});
	endtask

	task automatic t_masks();
		for (int i = 0; i < 8; i++)
			set_mask(i[3:0], 8'h41 + i[7:0]);
		for (int n = 1; n <= 8; n++) begin
			mem[8'h30] = {8'h40 + n[7:0], 8'h00};
			run(OP_MOVE, 16'h0000, '{16'h0060, 16'h0080, 16'h0000, 16'h0078});
			res(EX_MASK, n[15:0]);
		end
	endtask

	task automatic t_prio();
		logic [15:0] ct [3] = '{16'h027b, 16'h0278, 16'h0078};
		logic [15:0] of [3] = '{16'h0009, 16'h000a, 16'h0001};
		cbm_exit_e ek [3] = '{EX_PAR, EX_LIM, EX_MASK};
		mem[8'h30] = 16'h4100;
		for (int i = 0; i < 3; i++) begin
			mem[8'h48] = 16'h0000;
			run(OP_MOVE, 16'h0000, '{16'h0060, 16'h0090, 16'h0001, ct[i]});
			res(ek[i], of[i]);
			chk("stored", 32'h4100, {16'h0, mem[8'h48]});
		end
	endtask

	task automatic t_irq();
		int n0;
		n0 = gr_cnt;
		@(posedge clk);
		irq_pending <= 1'h1;
		run(OP_MOVE, 16'h0000, '{16'h0020, 16'h0040, 16'h0005, 16'h0600});
		@(posedge clk);
		irq_pending <= 1'h0;
		res(EX_IRQ, 16'h0000);
		chk("src", 32'h21, {16'h0, ctx_o.src});
		chk("limit", 32'h4, {16'h0, ctx_o.limit});
		chk("gr writes", n0, gr_cnt);
		chk("byte time", 32'h1, {31'h0, cyc < CHAR_CYC});
	endtask

	// Slow memory acks stall the buffer
	task automatic t_pack();
		ack_dly = 3;
		mem[8'h40] = 16'h0000;
		mem[8'h41] = 16'h0000;
		run(OP_UNPK, 16'h0000, '{16'h0020, 16'h0080, 16'h0002, 16'h0600});
		res(EX_LIM, 16'h000a);
		chk("unpack w0", 32'h0012, {16'h0, mem[8'h40]});
		chk("unpack w1", 32'h0034, {16'h0, mem[8'h41]});
		chk("unpack dst", 32'h84, {16'h0, ctx_o.dst});
		mem[8'h50] = 16'hff56;
		mem[8'h51] = 16'hee78;
		mem[8'h60] = 16'h0000;
		run(OP_PACK, 16'h0000, '{16'h00a0, 16'h00c0, 16'h0002, 16'h0600});
		res(EX_LIM, 16'h000a);
		chk("pack word", 32'h5678, {16'h0, mem[8'h60]});
		chk("pack src", 32'ha4, {16'h0, ctx_o.src});
		ack_dly = 0;
	endtask

	// ----------------------------------------
	// Verdict, sequence and watchdog
	// ----------------------------------------
	task automatic test_done();
		if (fails == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		foreach (mem[i])
			mem[i] = 16'h0000;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		t_check();
		t_limit();
		t_disc();
		t_masks();
		t_prio();
		t_irq();
		t_pack();
		test_done();
	end

	// Cut a hang short
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		test_done();
	end
endmodule
